// ===== hw/dfo_filter_chan.sv
// One channel of the two-filter averaging stage.
`timescale 1ns/1ns
`default_nettype none
module dfo_filter_chan (
  input  wire logic                          mclk,
  input  wire logic                          srst,
  input  wire logic                          sampleValid,
  input  wire logic signed [dfo_pkg::SAMPLE_W-1:0] sample,
  input  wire logic        [dfo_pkg::TC_W-1:0]     tcSmall,
  input  wire logic        [dfo_pkg::TC_W-1:0]     tcLarge,
  output var  logic signed [dfo_pkg::SAMPLE_W-1:0] filt_q,
  output var  logic                          usedLarge_q
);

  logic                              primed_q;
  logic signed [dfo_pkg::SAMPLE_W:0] diff;
  logic        [dfo_pkg::SAMPLE_W:0] absDiff;
  logic                              isLarge;
  logic signed [dfo_pkg::SAMPLE_W:0] step;
  logic signed [dfo_pkg::SAMPLE_W:0] sum;

  // ----------------------------------------------------------------
  // Filter selection and update
  // ----------------------------------------------------------------
  always_comb begin
    diff    = {sample[dfo_pkg::SAMPLE_W-1], sample} - {filt_q[dfo_pkg::SAMPLE_W-1], filt_q};
    absDiff = diff[dfo_pkg::SAMPLE_W] ? -diff : diff;
    // Exactly ten counts stays on the small filter.
    isLarge = absDiff > dfo_pkg::SMALL_LIMIT;
    step    = diff >>> (isLarge ? tcLarge : tcSmall);
    sum     = {filt_q[dfo_pkg::SAMPLE_W-1], filt_q} + step;
  end

  // The first sample after a restart loads directly, so the output does not crawl up from zero.
  always_ff @(posedge mclk) begin
    if (srst) begin
      filt_q      <= '0;
      usedLarge_q <= 1'b0;
      primed_q    <= 1'b0;
    end else if (sampleValid) begin
      primed_q    <= 1'b1;
      usedLarge_q <= primed_q && isLarge;
      filt_q      <= primed_q ? sum[dfo_pkg::SAMPLE_W-1:0] : sample;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  chk_large_select: assert property (sampleValid && primed_q && absDiff > dfo_pkg::SMALL_LIMIT |=> usedLarge_q)
    else $error("large step did not select the large filter");
  chk_small_select: assert property (sampleValid && primed_q && absDiff <= dfo_pkg::SMALL_LIMIT |=> !usedLarge_q)
    else $error("small step did not select the small filter");
  chk_filter_bound: assert property (sampleValid && primed_q && diff > 0 |=> filt_q <= $past(sample))
    else $error("filter overshot the sample");
  cov_large_step: cover property (sampleValid && primed_q && isLarge);
  cov_exact_ten:  cover property (sampleValid && primed_q && absDiff == 25'h000000A);

endmodule
`default_nettype wire

// ===== hw/dfo_output_path.sv
// Top of the measurement output path: trim, filtering, offset, commands and restart.
`timescale 1ns/1ns
`default_nettype none
module dfo_output_path (
  input  wire logic                                 mclk,
  input  wire logic                                 srst,
  input  wire logic                                 overridePinN,
  input  wire logic                                 sampleValid,
  input  wire logic        [dfo_pkg::CHAN_W-1:0]    sampleChan,
  input  wire logic signed [dfo_pkg::SAMPLE_W-1:0]  sampleData,
  input  wire dfo_pkg::dfo_cmd_t                    cmd,
  input  wire dfo_pkg::dfo_nv_t                     nvRestore,
  output var  dfo_pkg::dfo_rsp_t                    rsp_q,
  output var  dfo_pkg::dfo_nv_t                     nvWrite_q,
  output var  logic                                 modbusMode_q
);

  dfo_pkg::dfo_state_t             state_q;
  dfo_pkg::dfo_state_t             state_d;
  logic                            ovrSync1_q;
  logic                            ovrSync2_q;
  logic                            ovrSync3_q;
  logic                            ovrLevel_q;
  logic                            ovrRelease;
  logic                            overrideOn;
  logic                            filtClear;
  logic [dfo_pkg::TC_W-1:0]        tcSmall_q;
  logic [dfo_pkg::TC_W-1:0]        tcLarge_q;
  logic [dfo_pkg::ADDR_W-1:0]      baseAddr_q;
  logic                            mbEn_q;
  logic [dfo_pkg::GAIN_W-1:0]      gain_q   [dfo_pkg::NUM_CHAN];
  logic [dfo_pkg::SAMPLE_W-1:0]    offset_q [dfo_pkg::NUM_CHAN];
  logic signed [dfo_pkg::SAMPLE_W-1:0] filt [dfo_pkg::NUM_CHAN];
  logic [dfo_pkg::NUM_CHAN-1:0]    usedLarge;
  logic signed [dfo_pkg::SAMPLE_W+dfo_pkg::GAIN_W:0] product;
  logic signed [dfo_pkg::SAMPLE_W-1:0] trimmed;
  logic [dfo_pkg::ADDR_W-1:0]      chanOff;
  logic                            inRange;
  logic [dfo_pkg::CHAN_W-1:0]      cmdChan;
  logic                            take;
  logic                            rspOk;
  logic [dfo_pkg::SAMPLE_W-1:0]    rspData;
  logic [dfo_pkg::SAMPLE_W-1:0]    selFinal;
  logic [dfo_pkg::MB_W-1:0]        mbFraction;
  logic [dfo_pkg::SAMPLE_W-1:0]    zeroOffset;
  logic                            doWrite;

  // ----------------------------------------------------------------
  // Override pin synchroniser and release detection
  // ----------------------------------------------------------------
  // The pin is a slow mechanical contact, so a change is taken only once two late stages agree.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ovrSync1_q <= 1'b1;
      ovrSync2_q <= 1'b1;
      ovrSync3_q <= 1'b1;
      ovrLevel_q <= 1'b1;
    end else begin
      ovrSync1_q <= overridePinN;
      ovrSync2_q <= ovrSync1_q;
      ovrSync3_q <= ovrSync2_q;
      if (ovrSync2_q == ovrSync3_q) begin
        ovrLevel_q <= ovrSync3_q;
      end
    end
  end

  assign overrideOn = !ovrLevel_q;
  assign ovrRelease = overrideOn && ovrSync2_q && ovrSync3_q;

  // ----------------------------------------------------------------
  // Protocol mode and internal restart
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      dfo_pkg::ST_RESTART: begin
        state_d = (mbEn_q && !overrideOn) ? dfo_pkg::ST_MODBUS : dfo_pkg::ST_ASCII;
      end
      dfo_pkg::ST_ASCII: begin
        if (ovrRelease) begin
          state_d = dfo_pkg::ST_RESTART;
        end
      end
      dfo_pkg::ST_MODBUS: begin
        // Grounding the pin drops back to the known character protocol.
        if (overrideOn) begin
          state_d = dfo_pkg::ST_ASCII;
        end
      end
      default: begin
        state_d = dfo_pkg::ST_RESTART;
      end
    endcase
  end

  // A power-up reset passes through the same restart state as a pin release.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q      <= dfo_pkg::ST_RESTART;
      modbusMode_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      modbusMode_q <= state_d == dfo_pkg::ST_MODBUS;
    end
  end

  assign filtClear = srst || (state_q == dfo_pkg::ST_RESTART);

  // ----------------------------------------------------------------
  // Span trim and filters
  // ----------------------------------------------------------------
  always_comb begin
    product = $signed(sampleData) * $signed({1'b0, gain_q[sampleChan]});
    trimmed = product[dfo_pkg::GAIN_FRAC +: dfo_pkg::SAMPLE_W];
  end

  for (genvar g = 0; g < dfo_pkg::NUM_CHAN; g++) begin : gChan
    dfo_filter_chan uFilt (
      .mclk        (mclk),
      .srst        (filtClear),
      .sampleValid (sampleValid && (sampleChan == dfo_pkg::CHAN_W'(g))),
      .sample      (trimmed),
      .tcSmall     (tcSmall_q),
      .tcLarge     (tcLarge_q),
      .filt_q      (filt[g]),
      .usedLarge_q (usedLarge[g])
    );
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb begin
    chanOff  = cmd.addr - baseAddr_q;
    inRange  = chanOff < dfo_pkg::CHAN_SPAN;
    // Out-of-range addresses under override land on the first channel.
    cmdChan  = inRange ? chanOff[dfo_pkg::CHAN_W-1:0] : '0;
    take     = cmd.valid && (state_q != dfo_pkg::ST_RESTART) && (overrideOn || inRange);
    selFinal = filt[cmdChan] + offset_q[cmdChan];
    // Negative outputs clamp to the bottom of the Modbus range.
    mbFraction = selFinal[dfo_pkg::SAMPLE_W-1] ? '0 : selFinal[dfo_pkg::MB_LSB +: dfo_pkg::MB_W];
    zeroOffset = cmd.data - filt[cmdChan];
    rspOk    = state_q == dfo_pkg::ST_ASCII;
    rspData  = cmd.data;
    case (cmd.kind)
      dfo_pkg::READ_OUTPUT_CMD: begin
        rspData = selFinal;
      end
      dfo_pkg::MB_READ_IN_CMD: begin
        rspOk   = (state_q == dfo_pkg::ST_MODBUS) && (cmd.data[dfo_pkg::MB_W-1:0] == dfo_pkg::MB_INPUT_REG0);
        rspData = {{(dfo_pkg::SAMPLE_W-dfo_pkg::MB_W){1'b0}}, mbFraction};
      end
      default: begin
        rspData = cmd.data;
      end
    endcase
    doWrite  = take && rspOk;
  end

  // ----------------------------------------------------------------
  // Answer to the host
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= take;
      rsp_q.ok    <= rspOk;
      rsp_q.data  <= rspData;
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile settings
  // ----------------------------------------------------------------
  // Restored words from the storage loader are accepted at any time, but a host write in the
  // same cycle takes precedence so that a fresh trim is never overwritten by stale data.
  always_ff @(posedge mclk) begin
    if (srst) begin
      tcSmall_q  <= dfo_pkg::TC_SMALL_RST;
      tcLarge_q  <= dfo_pkg::TC_LARGE_RST;
      baseAddr_q <= dfo_pkg::ADDR_RST;
      mbEn_q     <= dfo_pkg::MB_EN_RST;
    end else if (doWrite && cmd.kind == dfo_pkg::SETUP_WRITE_CMD) begin
      tcSmall_q  <= cmd.data[dfo_pkg::SU_TC_SMALL_LSB +: dfo_pkg::TC_W];
      tcLarge_q  <= cmd.data[dfo_pkg::SU_TC_LARGE_LSB +: dfo_pkg::TC_W];
      baseAddr_q <= cmd.data[dfo_pkg::SU_ADDR_LSB +: dfo_pkg::ADDR_W];
      mbEn_q     <= cmd.data[dfo_pkg::SU_MB_EN_BIT];
    end else if (nvRestore.valid && nvRestore.kind == dfo_pkg::NV_SETUP) begin
      tcSmall_q  <= nvRestore.data[dfo_pkg::SU_TC_SMALL_LSB +: dfo_pkg::TC_W];
      tcLarge_q  <= nvRestore.data[dfo_pkg::SU_TC_LARGE_LSB +: dfo_pkg::TC_W];
      baseAddr_q <= nvRestore.data[dfo_pkg::SU_ADDR_LSB +: dfo_pkg::ADDR_W];
      mbEn_q     <= nvRestore.data[dfo_pkg::SU_MB_EN_BIT];
    end
  end

  for (genvar c = 0; c < dfo_pkg::NUM_CHAN; c++) begin : gCal
    always_ff @(posedge mclk) begin
      if (srst) begin
        offset_q[c] <= dfo_pkg::OFFSET_RST;
        gain_q[c]   <= dfo_pkg::GAIN_RST;
      end else if (doWrite && cmdChan == dfo_pkg::CHAN_W'(c)
                   && cmd.kind inside {dfo_pkg::ZERO_TRIM_CMD, dfo_pkg::SPAN_TRIM_CMD}) begin
        if (cmd.kind == dfo_pkg::ZERO_TRIM_CMD) begin
          offset_q[c] <= zeroOffset;
        end else begin
          gain_q[c]   <= cmd.data[dfo_pkg::GAIN_W-1:0];
        end
      end else if (nvRestore.valid && nvRestore.chan == dfo_pkg::CHAN_W'(c)) begin
        if (nvRestore.kind == dfo_pkg::NV_OFFSET) begin
          offset_q[c] <= nvRestore.data;
        end else if (nvRestore.kind == dfo_pkg::NV_GAIN) begin
          gain_q[c]   <= nvRestore.data[dfo_pkg::GAIN_W-1:0];
        end
      end
    end
  end

  // Every accepted trim or setup is pushed to the storage writer on the same edge that loads its register.
  always_ff @(posedge mclk) begin
    if (srst) begin
      nvWrite_q <= '0;
    end else begin
      nvWrite_q.valid <= doWrite && cmd.kind inside {dfo_pkg::SETUP_WRITE_CMD, dfo_pkg::ZERO_TRIM_CMD,
                                                     dfo_pkg::SPAN_TRIM_CMD};
      nvWrite_q.chan  <= cmdChan;
      if (cmd.kind == dfo_pkg::SETUP_WRITE_CMD) begin
        nvWrite_q.kind <= dfo_pkg::NV_SETUP;
        nvWrite_q.data <= cmd.data;
      end else if (cmd.kind == dfo_pkg::ZERO_TRIM_CMD) begin
        nvWrite_q.kind <= dfo_pkg::NV_OFFSET;
        nvWrite_q.data <= zeroOffset;
      end else begin
        nvWrite_q.kind <= dfo_pkg::NV_GAIN;
        nvWrite_q.data <= {{(dfo_pkg::SAMPLE_W-dfo_pkg::GAIN_W){1'b0}}, cmd.data[dfo_pkg::GAIN_W-1:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  chk_read_sum: assert property (take && rspOk && cmd.kind == dfo_pkg::READ_OUTPUT_CMD
      |=> rsp_q.valid && rsp_q.ok && rsp_q.data == $past(filt[cmdChan] + offset_q[cmdChan]))
    else $error("read answer is not filter plus offset");
  chk_zero_trim: assert property (doWrite && cmd.kind == dfo_pkg::ZERO_TRIM_CMD
      |=> offset_q[$past(cmdChan)] == $past(cmd.data - filt[cmdChan]))
    else $error("zero trim did not reach the requested output");
  chk_span_store: assert property (doWrite && cmd.kind == dfo_pkg::SPAN_TRIM_CMD
      |=> nvWrite_q.valid && nvWrite_q.kind == dfo_pkg::NV_GAIN && gain_q[nvWrite_q.chan] == nvWrite_q.data[15:0])
    else $error("span trim not stored");
  chk_setup_store: assert property (doWrite && cmd.kind == dfo_pkg::SETUP_WRITE_CMD
      |=> nvWrite_q.valid && tcSmall_q == nvWrite_q.data[3:0] && tcLarge_q == nvWrite_q.data[7:4])
    else $error("setup write not applied and stored");
  chk_addr_reject: assert property (cmd.valid && !overrideOn && !inRange |=> !rsp_q.valid)
    else $error("foreign address answered");
  chk_any_addr: assert property (cmd.valid && overrideOn && state_q == dfo_pkg::ST_ASCII |=> rsp_q.valid)
    else $error("override did not accept the address");
  chk_release_mode: assert property (state_q == dfo_pkg::ST_ASCII && ovrRelease
      |=> state_q == dfo_pkg::ST_RESTART ##1 modbusMode_q == $past(mbEn_q))
    else $error("pin release did not restart into the enabled mode");
  chk_mb_reg0: assert property (take && state_q == dfo_pkg::ST_MODBUS && cmd.kind == dfo_pkg::MB_READ_IN_CMD
      && cmd.data[15:0] == 16'h0000 |=> rsp_q.ok && rsp_q.data[23:16] == 8'h00
      && ($past(selFinal[dfo_pkg::SAMPLE_W-1]) ? rsp_q.data[15:0] == 16'h0000
          : rsp_q.data[15:0] == $past(selFinal[dfo_pkg::MB_LSB +: dfo_pkg::MB_W])))
    else $error("input register zero not answered as a fraction");
  cov_read:     cover property (take && cmd.kind == dfo_pkg::READ_OUTPUT_CMD);
  cov_modbus:   cover property (state_q == dfo_pkg::ST_MODBUS && take);
  cov_release:  cover property (ovrRelease);
  cov_large:    cover property (|usedLarge);

endmodule
`default_nettype wire

// ===== hw/dfo_pkg.sv
// Shared constants, encodings and carrier types of the dual filter output path.
// Notes on behaviour
// - Sample more than ten counts from held output goes through the large-signal filter.
// - Sample less than ten counts from held output goes through the small-signal filter.
// - Small and large time constants are set separately and kept in nonvolatile storage.
// - Final output is the filtered value plus the channel's output offset.
// - Zero trim loads the offset so output equals the request; offset is stored.
// - Span trim replaces the channel gain constant and stores it in nonvolatile memory.
// - Read output returns the addressed channel's final output value.
// - Override pin release or power-up restarts internally, entering Modbus mode if enabled; power-up always enters ASCII, as mbEn_q is still reset.
// - Modbus input register zero returns a 16-bit full-scale fraction.
// - Override pin grounded accepts any address; otherwise only the configured addresses.
package dfo_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int NUM_CHAN  = 4;
  localparam int CHAN_W    = 2;
  localparam int SAMPLE_W  = 24;
  localparam int TC_W      = 4;
  localparam int GAIN_W    = 16;
  localparam int GAIN_FRAC = 14;
  localparam int ADDR_W    = 8;
  localparam int MB_W      = 16;
  localparam int MB_LSB    = 7;

  // ----------------------------------------------------------------
  // Limits, field positions and reset values
  // ----------------------------------------------------------------
  localparam logic [SAMPLE_W:0]   SMALL_LIMIT     = 25'h000000A;
  localparam logic [ADDR_W-1:0]   CHAN_SPAN       = 8'h04;
  localparam int                  SU_TC_SMALL_LSB = 0;
  localparam int                  SU_TC_LARGE_LSB = 4;
  localparam int                  SU_ADDR_LSB     = 8;
  localparam int                  SU_MB_EN_BIT    = 16;
  localparam logic [TC_W-1:0]     TC_SMALL_RST    = 4'h6;
  localparam logic [TC_W-1:0]     TC_LARGE_RST    = 4'h1;
  localparam logic [ADDR_W-1:0]   ADDR_RST        = 8'h31;
  localparam logic                MB_EN_RST       = 1'b0;
  localparam logic [GAIN_W-1:0]   GAIN_RST        = 16'h4000;
  localparam logic [SAMPLE_W-1:0] OFFSET_RST      = 24'h000000;
  localparam logic [MB_W-1:0]     MB_INPUT_REG0   = 16'h0000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    SETUP_WRITE_CMD = 5'h01,
    ZERO_TRIM_CMD   = 5'h02,
    SPAN_TRIM_CMD   = 5'h04,
    READ_OUTPUT_CMD = 5'h08,
    MB_READ_IN_CMD  = 5'h10
  } dfo_cmd_kind_t;

  typedef enum logic [2:0] {
    NV_SETUP  = 3'h1,
    NV_OFFSET = 3'h2,
    NV_GAIN   = 3'h4
  } dfo_nv_kind_t;

  typedef enum logic [2:0] {
    ST_RESTART = 3'h1,
    ST_ASCII   = 3'h2,
    ST_MODBUS  = 3'h4
  } dfo_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                valid;
    dfo_cmd_kind_t       kind;
    logic [ADDR_W-1:0]   addr;
    logic [SAMPLE_W-1:0] data;
  } dfo_cmd_t;

  typedef struct packed {
    logic                valid;
    logic                ok;
    logic [SAMPLE_W-1:0] data;
  } dfo_rsp_t;

  typedef struct packed {
    logic                valid;
    dfo_nv_kind_t        kind;
    logic [CHAN_W-1:0]   chan;
    logic [SAMPLE_W-1:0] data;
  } dfo_nv_t;

endpackage

// ===== verif/dfo_host_model.sv
// Host-side model that hands parsed commands to the output path and collects replies.
`timescale 1ns/1ns
`default_nettype none
module dfo_host_model (
  input  wire logic              mclk,
  output var  dfo_pkg::dfo_cmd_t cmd,
  input  wire dfo_pkg::dfo_rsp_t rsp_q,
  input  wire dfo_pkg::dfo_nv_t  nvWrite_q
);
  // Character framing (300 baud, seven data bits, mark parity, one stop bit) is done by the serial
  // front end, so this model only hands over commands that are already parsed.
  initial begin
    cmd = '{valid: 1'b0, kind: dfo_pkg::READ_OUTPUT_CMD, addr: 8'h5A, data: 24'hA5A5A5};
  end

  task automatic issue(input dfo_pkg::dfo_cmd_kind_t k, input logic [7:0] a, input logic [23:0] d,
                       output dfo_pkg::dfo_rsp_t r, output dfo_pkg::dfo_nv_t n, output logic got);
    int i;
    got = 1'b0;
    r = '0;
    n = '0;
    @(negedge mclk);
    cmd = '{valid: 1'b1, kind: k, addr: a, data: d};
    @(negedge mclk);
    // Idle fields are inverted so a stale command can never be mistaken for a fresh one.
    cmd = '{valid: 1'b0, kind: k, addr: ~a, data: ~d};
    for (i = 0; i < 3 && !got; i++) begin
      if (rsp_q.valid === 1'b1) begin
        got = 1'b1;
        r = rsp_q;
        n = nvWrite_q;
      end else begin
        @(negedge mclk);
      end
    end
  endtask
endmodule
`default_nettype wire

// ===== verif/dual_filter_output_path_bench.sv
// Self-checking bench of the dual filter output path.
`timescale 1ns/1ns
`default_nettype none
module dual_filter_output_path_bench;
  logic                                mclk;
  logic                                srst;
  logic                                overridePinN;
  logic                                sampleValid;
  logic        [dfo_pkg::CHAN_W-1:0]   sampleChan;
  logic signed [dfo_pkg::SAMPLE_W-1:0] sampleData;
  dfo_pkg::dfo_cmd_t                   cmd;
  dfo_pkg::dfo_nv_t                    nvRestore;
  dfo_pkg::dfo_nv_t                    nvWrite_q;
  dfo_pkg::dfo_rsp_t                   rsp_q;
  logic                                modbusMode_q;
  dfo_pkg::dfo_rsp_t                   r;
  dfo_pkg::dfo_nv_t                    n;
  logic                                got;
  int                                  err_total = 0;
  int                                  cmp_count = 0;
  int                                  cycles = 0;

  dfo_output_path u_dfo_output_path (.mclk(mclk), .srst(srst), .overridePinN(overridePinN),
    .sampleValid(sampleValid), .sampleChan(sampleChan), .sampleData(sampleData), .cmd(cmd),
    .nvRestore(nvRestore), .rsp_q(rsp_q), .nvWrite_q(nvWrite_q), .modbusMode_q(modbusMode_q));
  dfo_host_model u_dfo_host_model (.mclk(mclk), .cmd(cmd), .rsp_q(rsp_q), .nvWrite_q(nvWrite_q));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // The ceiling is some thirty times the length of the whole sequence.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      print_verdict();
    end
  end

  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic send(input dfo_pkg::dfo_cmd_kind_t k, input logic [7:0] a, input logic [23:0] d);
    u_dfo_host_model.issue(k, a, d, r, n, got);
  endtask

  task automatic rd(input logic [7:0] a, input logic [23:0] exp);
    send(dfo_pkg::READ_OUTPUT_CMD, a, 24'h000000);
    check("read answered", 24'(got), 24'h000001);
    check("read data", r.data, exp);
  endtask

  task automatic samp(input logic [1:0] ch, input logic [23:0] v);
    @(negedge mclk);
    sampleValid = 1'b1;
    sampleChan = ch;
    sampleData = v;
    @(negedge mclk);
    sampleValid = 1'b0;
    sampleData = ~v;
  endtask

  task automatic t_filter();
    check("mode after reset", 24'(modbusMode_q), 24'h000000);
    rd(8'h31, 24'h000000);
    samp(2'h0, 24'd100);
    rd(8'h31, 24'd100);
    samp(2'h0, 24'd110);
    rd(8'h31, 24'd100);
    samp(2'h0, 24'd111);
    rd(8'h31, 24'd105);
    samp(2'h0, 24'd100);
    rd(8'h31, 24'd104);
    $display("filter test done");
  endtask

  task automatic t_setup_trim();
    send(dfo_pkg::SETUP_WRITE_CMD, 8'h31, 24'h003131);
    check("setup store kind", 24'(n.kind), 24'(dfo_pkg::NV_SETUP));
    check("setup store data", n.data, 24'h003131);
    samp(2'h0, 24'd108);
    samp(2'h0, 24'd126);
    rd(8'h31, 24'd108);
    send(dfo_pkg::ZERO_TRIM_CMD, 8'h31, 24'd1000);
    check("offset store kind", 24'(n.kind), 24'(dfo_pkg::NV_OFFSET));
    check("offset store data", n.data, 24'd892);
    rd(8'h31, 24'd1000);
    send(dfo_pkg::SPAN_TRIM_CMD, 8'h32, 24'h008000);
    check("gain store kind", 24'(n.kind), 24'(dfo_pkg::NV_GAIN));
    check("gain store chan", 24'(n.chan), 24'h000001);
    check("gain store data", n.data, 24'h008000);
    samp(2'h1, 24'd50);
    rd(8'h32, 24'd100);
    @(negedge mclk);
    nvRestore = '{valid: 1'b1, kind: dfo_pkg::NV_OFFSET, chan: 2'h2, data: 24'h000010};
    @(negedge mclk);
    nvRestore = '0;
    rd(8'h33, 24'h000010);
    $display("setup and trim test done");
  endtask

  task automatic t_addr_mode();
    int i;
    send(dfo_pkg::READ_OUTPUT_CMD, 8'h40, 24'h000000);
    check("foreign address answered", 24'(got), 24'h000000);
    send(dfo_pkg::MB_READ_IN_CMD, 8'h31, 24'h000000);
    check("register read in ascii ok", 24'(r.ok), 24'h000000);
    @(negedge mclk);
    overridePinN = 1'b0;
    repeat (6) @(negedge mclk);
    rd(8'h40, 24'd1000);
    send(dfo_pkg::SETUP_WRITE_CMD, 8'h40, 24'h013131);
    check("setup under override ok", 24'(r.ok), 24'h000001);
    overridePinN = 1'b1;
    for (i = 0; i < 12 && modbusMode_q !== 1'b1; i++) begin
      @(negedge mclk);
    end
    check("mode after release", 24'(modbusMode_q), 24'h000001);
    send(dfo_pkg::MB_READ_IN_CMD, 8'h31, 24'h000000);
    check("register zero ok", 24'(r.ok), 24'h000001);
    check("register zero cleared", 24'(r.data[15:0]), 24'h000006);
    samp(2'h0, 24'd1000);
    send(dfo_pkg::MB_READ_IN_CMD, 8'h31, 24'h000000);
    check("register zero value", 24'(r.data[15:0]), 24'h00000E);
    send(dfo_pkg::MB_READ_IN_CMD, 8'h31, 24'h000001);
    check("register one ok", 24'(r.ok), 24'h000000);
    send(dfo_pkg::READ_OUTPUT_CMD, 8'h31, 24'h000000);
    check("ascii read in modbus ok", 24'(r.ok), 24'h000000);
    overridePinN = 1'b0;
    repeat (6) @(negedge mclk);
    check("mode after grounding", 24'(modbusMode_q), 24'h000000);
    $display("address and mode test done");
  endtask

  initial begin
    srst = 1'b1;
    overridePinN = 1'b1;
    sampleValid = 1'b0;
    sampleChan = 2'h0;
    sampleData = 24'h000000;
    nvRestore = '0;
    repeat (5) @(negedge mclk);
    srst = 1'b0;
    repeat (2) @(negedge mclk);
    t_filter();
    t_setup_trim();
    t_addr_mode();
    print_verdict();
  end
endmodule
`default_nettype wire
